// file: rtl/stcs_pkg.sv
package stcs_pkg;
   // Register indices (printed offsets not multiples of four: byte address = 4 * index)
   localparam logic [15:0] IDX_ERROR_STATE = 16'h1a02;
   localparam logic [15:0] IDX_ERROR_CODE = 16'h1a03;
   localparam logic [15:0] IDX_STATE_WORD = 16'h1a06;
   localparam logic [15:0] IDX_ACTIVE_FLAG = 16'h1a10;
   localparam logic [15:0] IDX_SELECTED_FLAG = 16'h1a1a;
   localparam logic [15:0] IDX_ERROR_FLAG = 16'h1a1d;
   localparam logic [15:0] IDX_ACK_FLAG = 16'h1a1e;
   localparam logic [15:0] IDX_DELAY = 16'h47d5;
   localparam logic [15:0] IDX_OUT_SELECT = 16'h47a8;
   localparam logic [15:0] IDX_BRAKE_ATTACHED = 16'h47d4;
   localparam logic [15:0] IDX_CONTROL = 16'h4e00;
   localparam logic [15:0] IDX_FAULT = 16'h4e01;
   localparam int ADDR_W = 18;
   // State word bit positions
   localparam int SW_ACTIVE_BIT = 0;
   localparam int SW_SELECTED_BIT = 10;
   localparam int SW_ERROR_BIT = 13;
   localparam int SW_ACK_BIT = 14;
   localparam int STATUS_ACTIVE_BIT = 0;
   // Safe output selector code for cutoff-active
   localparam logic [7:0] OUT_SEL_CUTOFF = 8'h01;
   // Reset values
   localparam logic [15:0] DELAY_RESET = 16'h0014;
   localparam logic [7:0] OUT_SEL_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
   localparam int REACT_MS = 10;
   localparam logic [15:0] DELAY_MAX_MS = 16'hea60;
   typedef enum logic [1:0] {
      STCS_IDLE = 2'b00,
      STCS_BRAKE = 2'b01,
      STCS_CUT = 2'b11
   } stcs_state_e;
endpackage

// file: rtl/stcs_sequencer.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module stcs_sequencer
   import stcs_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic safe_input_req,
   input wire logic safe_fieldbus_req,
   input wire logic app_req,
   input wire logic fault_req,
   input wire logic module_error,
   input wire logic ack_needed,
   input wire logic [7:0] error_state_in,
   input wire logic [7:0] error_code_in,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic brake_engage,
   output logic motor_current_en,
   output logic cutoff_active_flag,
   output logic cutoff_selected_flag,
   output logic safety_status_word_one_bit0,
   output logic safety_status_word_two_bit0,
   output logic safe_output
);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

   // Pin-side inputs pass two flops before use
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic [NSYNC-1:0] raw_in;
   logic [7:0] err_state_s1, err_state_s2, err_code_s1, err_code_s2;
   assign raw_in = {ack_needed, module_error, fault_req, app_req,
                    safe_fieldbus_req, safe_input_req};
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= '0;
         sync2 <= '0;
         err_state_s1 <= 8'h00;
         err_state_s2 <= 8'h00;
         err_code_s1 <= 8'h00;
         err_code_s2 <= 8'h00;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         err_state_s1 <= error_state_in;
         err_state_s2 <= err_state_s1;
         err_code_s1 <= error_code_in;
         err_code_s2 <= err_code_s1;
      end
   end

   // Registers written by software
   logic [15:0] delay_ms;
   logic [7:0] out_select;
   logic brake_attached;
   logic sw_req;

   // One shared instance: all sources ORed into a single request
   logic any_req;
   assign any_req = sync2[0] | sync2[1] | sync2[2] | sync2[3] | sw_req;

   // Millisecond tick
   logic [TW-1:0] tick_cnt;
   logic ms_tick;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= '0;
         ms_tick <= 1'b0;
      end else begin
         ms_tick <= (tick_cnt == TICK_LAST);
         tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
      end
   end

   // Sequencer
   stcs_state_e state;
   logic [15:0] wait_ms;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= STCS_IDLE;
         wait_ms <= 16'h0000;
      end else begin
         case (state)
            STCS_IDLE: begin
               if (any_req) begin
                  if (brake_attached && delay_ms != 16'h0000) begin
                     state <= STCS_BRAKE;
                     wait_ms <= delay_ms;
                  end else begin
                     state <= STCS_CUT;
                  end
               end
            end
            STCS_BRAKE: begin
               // Once started, the sequence completes even if the request drops
               if (ms_tick) begin
                  if (wait_ms <= 16'h0001) begin
                     state <= STCS_CUT;
                  end
                  wait_ms <= wait_ms - 16'h0001;
               end
            end
            STCS_CUT: begin
               if (!any_req) begin
                  state <= STCS_IDLE;
               end
            end
            default: state <= STCS_IDLE;
         endcase
      end
   end

   // Outputs, straight from flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         brake_engage <= 1'b1;
         motor_current_en <= 1'b0;
         cutoff_active_flag <= 1'b1;
         cutoff_selected_flag <= 1'b0;
         safety_status_word_one_bit0 <= 1'b1;
         safety_status_word_two_bit0 <= 1'b1;
         safe_output <= 1'b0;
      end else begin
         brake_engage <= brake_attached && state != STCS_IDLE;
         motor_current_en <= (state != STCS_CUT);
         cutoff_active_flag <= (state == STCS_CUT);
         cutoff_selected_flag <= any_req;
         safety_status_word_one_bit0 <= (state == STCS_CUT);
         safety_status_word_two_bit0 <= (state == STCS_CUT);
         safe_output <= (out_select == OUT_SEL_CUTOFF) && (state == STCS_CUT);
      end
   end

   // AXI4-Lite slave
   logic aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic [15:0] wr_idx, rd_idx;
   logic wr_go;
   assign wr_idx = aw_addr[ADDR_W-1:2];
   assign rd_idx = s_axi_araddr[ADDR_W-1:2];
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         delay_ms <= DELAY_RESET;
         out_select <= OUT_SEL_RESET;
         brake_attached <= 1'b0;
         sw_req <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            case (wr_idx)
               IDX_DELAY: begin
                  // Values beyond 60 s are refused
                  if (w_strb[1:0] == 2'b11 && w_data[15:0] <= DELAY_MAX_MS) begin
                     delay_ms <= w_data[15:0];
                  end else begin
                     s_axi_bresp <= RESP_SLVERR;
                  end
               end
               IDX_OUT_SELECT: begin
                  if (w_strb[0]) begin
                     out_select <= w_data[7:0];
                  end
               end
               IDX_BRAKE_ATTACHED: begin
                  if (w_strb[0]) begin
                     brake_attached <= w_data[0];
                  end
               end
               IDX_CONTROL: begin
                  if (w_strb[0]) begin
                     sw_req <= w_data[0];
                  end
               end
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end
      end
   end

   logic [31:0] state_word;
   always_comb begin
      state_word = 32'h0000_0000;
      state_word[SW_ACTIVE_BIT] = cutoff_active_flag;
      state_word[SW_SELECTED_BIT] = cutoff_selected_flag;
      state_word[SW_ERROR_BIT] = sync2[4];
      state_word[SW_ACK_BIT] = sync2[5];
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (rd_idx)
               IDX_ERROR_STATE: s_axi_rdata[7:0] <= err_state_s2;
               IDX_ERROR_CODE: s_axi_rdata[7:0] <= err_code_s2;
               IDX_STATE_WORD: s_axi_rdata <= state_word;
               IDX_ACTIVE_FLAG: s_axi_rdata[0] <= cutoff_active_flag;
               IDX_SELECTED_FLAG: s_axi_rdata[0] <= cutoff_selected_flag;
               IDX_ERROR_FLAG: s_axi_rdata[0] <= sync2[4];
               IDX_ACK_FLAG: s_axi_rdata[0] <= sync2[5];
               IDX_DELAY: s_axi_rdata[15:0] <= delay_ms;
               IDX_OUT_SELECT: s_axi_rdata[7:0] <= out_select;
               IDX_BRAKE_ATTACHED: s_axi_rdata[0] <= brake_attached;
               IDX_CONTROL: s_axi_rdata[0] <= sw_req;
               IDX_FAULT: s_axi_rdata[0] <= sync2[3];
               default: s_axi_rresp <= RESP_SLVERR;
            endcase
         end
      end
   end

   // Checks
   // Counts up to the first effect, brake or cut; a long legal brake delay must not trip it
   int unsigned since_req;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         since_req <= 0;
      end else if (any_req && motor_current_en && !brake_engage) begin
         since_req <= since_req + 1;
      end else begin
         since_req <= 0;
      end
   end

   sequence req_rise_s;
      $rose(any_req) && state == STCS_IDLE;
   endsequence

   property current_off_p;
      @(posedge core_clk) disable iff (!nrst) cutoff_active_flag |-> !motor_current_en;
   endproperty

   cut_no_current_a: assert property (current_off_p)
      else $error("motor current enabled during cutoff");

   brake_first_a: assert property (@(posedge core_clk) disable iff (!nrst)
      req_rise_s ##0 (brake_attached && delay_ms != 16'h0000)
      |=> ##1 (brake_engage && motor_current_en))
      else $error("brake not engaged ahead of cutoff");

   zero_delay_a: assert property (@(posedge core_clk) disable iff (!nrst)
      req_rise_s ##0 (brake_attached && delay_ms == 16'h0000)
      |=> ##1 (brake_engage && !motor_current_en))
      else $error("zero delay did not cut together");

   react_time_a: assert property (@(posedge core_clk) disable iff (!nrst)
      since_req < (REACT_MS * TICK_CYC) + 4)
      else $error("cutoff too slow");

   release_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (state == STCS_CUT && any_req) |=> state == STCS_CUT)
      else $error("cutoff released while requested");

   word_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
      safety_status_word_one_bit0 == cutoff_active_flag
      && safety_status_word_two_bit0 == cutoff_active_flag)
      else $error("status bit differs from active flag");

   out_mirror_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ($past(out_select) == OUT_SEL_CUTOFF) |-> safe_output == cutoff_active_flag)
      else $error("safe output not mirroring cutoff");

   reach_after_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(cutoff_active_flag) |-> $past(state) == STCS_CUT
      && ($past(state, 2) != STCS_IDLE || !$past(brake_attached, 2)
      || $past(delay_ms, 2) == 16'h0000))
      else $error("cutoff reported before sequence end");

   selected_a: assert property (@(posedge core_clk) disable iff (!nrst)
      any_req |=> cutoff_selected_flag)
      else $error("selected flag missed request");

   // Brake must hold while current is cut, or a hanging load drops
   brake_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ($past(brake_attached) && !motor_current_en) |-> brake_engage)
      else $error("brake released during cutoff");

   delay_range_a: assert property (@(posedge core_clk) disable iff (!nrst)
      delay_ms <= DELAY_MAX_MS)
      else $error("delay above sixty seconds");
endmodule
`default_nettype wire

// file: verification/stcs_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module stcs_far_side (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic in_cmd,
   input wire logic fb_cmd,
   input wire logic slow,
   output logic safe_input_req,
   output logic safe_fieldbus_req
);
   logic [2:0] in_lag;
   logic [2:0] fb_lag;
   // Slow mode stands for a late fieldbus cycle or a sluggish contact
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         in_lag <= 3'h0;
         fb_lag <= 3'h0;
      end else begin
         in_lag <= {in_lag[1:0], in_cmd};
         fb_lag <= {fb_lag[1:0], fb_cmd};
      end
   end
   assign safe_input_req = slow ? in_lag[2] : in_lag[0];
   assign safe_fieldbus_req = slow ? fb_lag[2] : fb_lag[0];
endmodule
`default_nettype wire

// file: verification/safe_torque_cutoff_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
 $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module safe_torque_cutoff_sequencer_tb;
   import stcs_pkg::*;
   localparam int TCK = 10;
   logic core_clk = 1'b0, nrst = 1'b0, in_cmd = 1'b0, fb_cmd = 1'b0, slow = 1'b0;
   logic safe_input_req, safe_fieldbus_req, app_req = 1'b0, fault_req = 1'b0;
   logic module_error = 1'b0, ack_needed = 1'b0;
   logic [7:0] error_state_in = 8'h00, error_code_in = 8'h00;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, v;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic brake_engage, motor_current_en, cutoff_active_flag, cutoff_selected_flag;
   logic safety_status_word_one_bit0, safety_status_word_two_bit0, safe_output;
   int error_cnt = 0, samples_checked = 0, seed = 35865, m_delay, m_sel, n;
   always #20 core_clk = ~core_clk;
   stcs_far_side stcs_far_side_inst (.core_clk, .nrst, .in_cmd, .fb_cmd, .slow,
      .safe_input_req, .safe_fieldbus_req);
   stcs_sequencer #(.TICK_CYC(TCK)) stcs_sequencer_inst (.core_clk, .nrst, .safe_input_req,
      .safe_fieldbus_req, .app_req, .fault_req, .module_error, .ack_needed, .error_state_in,
      .error_code_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .brake_engage, .motor_current_en, .cutoff_active_flag, .cutoff_selected_flag,
      .safety_status_word_one_bit0, .safety_status_word_two_bit0, .safe_output);
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic timeout;
      error_cnt++;
      $display("ERROR wait expected answer seen none");
      print_verdict();
   endtask
   task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge core_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && k < 50);
      s_axi_bready <= 1'b0;
      if (k >= 50) timeout();
      `CHK("bresp", er, s_axi_bresp)
   endtask
   task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, input logic [1:0] er);
      int k;
      k = 0;
      @(posedge core_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && k < 50);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      if (k >= 50) timeout();
      `CHK("rresp", er, s_axi_rresp)
   endtask
   task automatic drive_src(input int s, input logic val);
      if (s == 4) begin
         axi_wr(IDX_CONTROL, {31'h0, val}, RESP_OKAY);
      end else begin
         @(posedge core_clk);
         case (s)
            0: in_cmd <= val;
            1: fb_cmd <= val;
            2: app_req <= val;
            default: fault_req <= val;
         endcase
      end
   endtask
   // Which 0 watches the current enable, 1 the brake
   task automatic wait_for(input int which, input logic val, output int cyc);
      cyc = 0;
      do begin
         @(negedge core_clk);
         cyc++;
      end while ((which == 0 ? motor_current_en : brake_engage) !== val && cyc < 3000);
      if (cyc >= 3000) timeout();
   endtask
   function automatic logic [31:0] exp_word(input logic a, s, e, k);
      exp_word = 32'h0;
      exp_word[SW_ACTIVE_BIT] = a;
      exp_word[SW_SELECTED_BIT] = s;
      exp_word[SW_ERROR_BIT] = e;
      exp_word[SW_ACK_BIT] = k;
   endfunction
   initial begin
      repeat (16) @(posedge core_clk);
      `CHK("reset current", 1'b0, motor_current_en)
      `CHK("reset active", 1'b1, cutoff_active_flag)
      nrst <= 1'b1;
      m_delay = DELAY_RESET;
      axi_rd(IDX_DELAY, rd, RESP_OKAY);
      `CHK("delay reset", 32'(m_delay), rd)
      axi_rd(IDX_OUT_SELECT, rd, RESP_OKAY);
      `CHK("selector reset", 32'(OUT_SEL_RESET), rd)
      axi_rd(IDX_STATE_WORD, rd, RESP_OKAY);
      `CHK("idle word", exp_word(0, 0, 0, 0), rd)
      `CHK("idle current", 1'b1, motor_current_en)
      $display("test reset done");
      axi_wr(IDX_DELAY, 32'h0000ea61, RESP_SLVERR);
      axi_rd(IDX_DELAY, rd, RESP_OKAY);
      `CHK("delay kept", 32'(m_delay), rd)
      axi_wr(IDX_DELAY, 32'(DELAY_MAX_MS), RESP_OKAY);
      m_delay = 60000;
      axi_rd(IDX_DELAY, rd, RESP_OKAY);
      `CHK("delay max", 32'(m_delay), rd)
      axi_rd(16'h0100, rd, RESP_SLVERR);
      `CHK("unmapped data", 32'h0, rd)
      $display("test refusal done");
      for (int s = 0; s < 5; s++) begin
         m_sel = (s % 2 == 0) ? 1 : 0;
         axi_wr(IDX_OUT_SELECT, 32'(m_sel), RESP_OKAY);
         slow <= s[0];
         drive_src(s, 1'b1);
         wait_for(0, 1'b0, n);
         `CHK("in time", 1'b1, n < REACT_MS * TCK)
         `CHK("active", 1'b1, cutoff_active_flag)
         `CHK("selected pin", 1'b1, cutoff_selected_flag)
         `CHK("no brake", 1'b0, brake_engage)
         `CHK("bus one", 1'b1, safety_status_word_one_bit0)
         `CHK("bus two", 1'b1, safety_status_word_two_bit0)
         `CHK("safe out", m_sel == 1, safe_output)
         axi_rd(IDX_STATE_WORD, rd, RESP_OKAY);
         `CHK("cut word", exp_word(1, 1, 0, 0), rd)
         axi_rd(IDX_SELECTED_FLAG, rd, RESP_OKAY);
         `CHK("selected", 32'h1, rd)
         axi_rd(IDX_ACTIVE_FLAG, rd, RESP_OKAY);
         `CHK("active reg", 32'h1, rd)
         drive_src(s, 1'b0);
         wait_for(0, 1'b1, n);
         `CHK("released", 1'b0, cutoff_active_flag)
         `CHK("selected off", 1'b0, cutoff_selected_flag)
         `CHK("safe out off", 1'b0, safe_output)
      end
      $display("test sources done");
      axi_wr(IDX_BRAKE_ATTACHED, 32'h1, RESP_OKAY);
      for (int d = 3; d >= 0; d -= 3) begin
         axi_wr(IDX_DELAY, 32'(d), RESP_OKAY);
         drive_src(1, 1'b1);
         wait_for(1, 1'b1, n);
         `CHK("cut with brake", d == 0, !motor_current_en)
         `CHK("early report", d == 0, cutoff_active_flag)
         wait_for(0, 1'b0, n);
         `CHK("delay low", 1'b1, n >= (d - 1) * TCK)
         `CHK("delay high", 1'b1, n <= d * TCK + 4)
         n = 0;
         // Cutoff must hold while the request stays, not just on entry
         repeat (40) begin
            @(negedge core_clk);
            if (motor_current_en !== 1'b0 || brake_engage !== 1'b1) n++;
         end
         `CHK("held off", 0, n)
         drive_src(1, 1'b0);
         wait_for(0, 1'b1, n);
         `CHK("brake free", 1'b0, brake_engage)
      end
      $display("test brake done");
      drive_src(0, 1'b1);
      drive_src(3, 1'b1);
      wait_for(0, 1'b0, n);
      drive_src(0, 1'b0);
      repeat (30) @(negedge core_clk);
      `CHK("one left", 1'b0, motor_current_en)
      axi_rd(IDX_FAULT, rd, RESP_OKAY);
      `CHK("fault readback", 32'h1, rd)
      drive_src(3, 1'b0);
      wait_for(0, 1'b1, n);
      `CHK("none left", 1'b0, cutoff_active_flag)
      $display("test overlap done");
      for (int i = 0; i < 6; i++) begin
         v = $random(seed);
         @(posedge core_clk);
         module_error <= v[0];
         ack_needed <= v[1];
         error_state_in <= v[15:8];
         error_code_in <= v[23:16];
         repeat (4) @(posedge core_clk);
         axi_rd(IDX_STATE_WORD, rd, RESP_OKAY);
         `CHK("error word", exp_word(0, 0, v[0], v[1]), rd)
         axi_rd(IDX_ERROR_FLAG, rd, RESP_OKAY);
         `CHK("error flag", {31'h0, v[0]}, rd)
         axi_rd(IDX_ACK_FLAG, rd, RESP_OKAY);
         `CHK("ack flag", {31'h0, v[1]}, rd)
         axi_rd(IDX_ERROR_STATE, rd, RESP_OKAY);
         `CHK("error state", {24'h0, v[15:8]}, rd)
         axi_rd(IDX_ERROR_CODE, rd, RESP_OKAY);
         `CHK("error code", {24'h0, v[23:16]}, rd)
      end
      $display("test errors done");
      print_verdict();
   end
endmodule
`default_nettype wire
